// ==== viu_regs.svh ====
// Notes on behaviour
// - Status register returns the number of the source now being serviced.
// - Pending register shows one bit per source, fast at 0, system at 1.
// - A pending bit reads zero when its source has no pending request.
// - Mask register shows one for each enabled source, zero for disabled.
// - Core status bit 0 is fast line active, bit 1 normal line active.
// - Enable command sets mask bits written with one; zeros change nothing.
// - Disable command clears mask bits written with one; zeros change nothing.
// - Clear command removes pending requests written with one.
// - Set command forces pending requests written with one.
// - Any write to end-of-service location signals completion, data ignored.
// - Spurious vector holds a full 32-bit written address and reads back.
// - Spurious vector returned on spurious normal or fast vector reads.
// - Debug control bit 0 is protection mode enable.
// - General mask bit 1 holds both core request outputs inactive.
// - With general mask clear, request outputs follow normal arbitration.
// - Fast forcing enable sets forcing per written one; bit 0 reserved.
// - Normal vector read returns spurious vector when no normal source is active or one is in service.
`ifndef VIU_REGS_SVH
`define VIU_REGS_SVH
`define VIU_OFF_NVR 12'h100
`define VIU_OFF_FVR 12'h104
`define VIU_OFF_ISR 12'h108
`define VIU_OFF_IPR 12'h10C
`define VIU_OFF_IMR 12'h110
`define VIU_OFF_CISR 12'h114
`define VIU_OFF_IECR 12'h120
`define VIU_OFF_IDCR 12'h124
`define VIU_OFF_ICCR 12'h128
`define VIU_OFF_ISCR 12'h12C
`define VIU_OFF_EOS 12'h130
`define VIU_OFF_SPU 12'h134
`define VIU_OFF_DBG 12'h138
`define VIU_OFF_FFER 12'h140
`define VIU_OFF_EVST 12'h150
`define VIU_OFF_EVMSK 12'h154
`define VIU_DBG_PROTECTION 0
`define VIU_DBG_LINE_MASK 1
`define VIU_CL_FAST 0
`define VIU_CL_NORM 1
`define VIU_EV_EOS 0
`define VIU_EV_SPUR 1
`endif

// ==== viu_pkg.sv ====
package viu_pkg;
    typedef logic [31:0] viu_word_t;
    typedef logic [4:0] viu_src_t;
    typedef enum logic [1:0] {
        VIU_IDLE = 2'b00,
        VIU_SERV = 2'b01
    } viu_state_t;
endpackage : viu_pkg

// ==== viu_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.svh"
module viu_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt sources, asynchronous, active high, pended on the rising edge
    input wire viu_pkg::viu_word_t srcIn,
    // Core request lines, active low
    output logic normalRequestLine_n,
    output logic fastRequestLine_n,
    // Event interrupt
    output logic eventIrq
);
    import viu_pkg::*;

    // ============================================================
    // Source synchronisers
    logic [31:0] syncA, syncB, syncC;
    always_ff @(posedge core_clk) begin
        syncA <= srcIn;
        syncB <= syncA;
        syncC <= syncB;
    end
    // A change counts only once the second and third stages agree
    logic [31:0] srcLvl_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            srcLvl_reg <= 32'h0;
        end else begin
            srcLvl_reg <= (syncB & syncC) | (srcLvl_reg & (syncB | syncC));
        end
    end
    logic [31:0] srcRise;
    assign srcRise = syncB & syncC & ~srcLvl_reg;

    // ============================================================
    // Bus address phase capture
    logic wrPend_reg, rdPend_reg;
    logic [11:0] addr_reg;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg <= 12'h000;
        end else begin
            wrPend_reg <= take && hwrite;
            rdPend_reg <= take && !hwrite;
            if (take) begin
                addr_reg <= haddr;
            end
        end
    end
    logic wEn, wSet, wClr, wPset, wPclr, wEos, wSpu, wDbg, wFfer, wEvst, wEvmsk;
    assign wEn = wrPend_reg && addr_reg == `VIU_OFF_IECR;
    assign wClr = wrPend_reg && addr_reg == `VIU_OFF_IDCR;
    assign wPclr = wrPend_reg && addr_reg == `VIU_OFF_ICCR;
    assign wPset = wrPend_reg && addr_reg == `VIU_OFF_ISCR;
    assign wEos = wrPend_reg && addr_reg == `VIU_OFF_EOS;
    assign wSpu = wrPend_reg && addr_reg == `VIU_OFF_SPU;
    assign wDbg = wrPend_reg && addr_reg == `VIU_OFF_DBG;
    assign wFfer = wrPend_reg && addr_reg == `VIU_OFF_FFER;
    assign wEvst = wrPend_reg && addr_reg == `VIU_OFF_EVST;
    assign wEvmsk = wrPend_reg && addr_reg == `VIU_OFF_EVMSK;
    assign wSet = wPset;

    // ============================================================
    // Mask, pending, configuration
    logic [31:0] mask_reg, pend_reg, forceEn_reg, spuVec_reg;
    logic [1:0] debug_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mask_reg <= 32'h0;
        end else if (wEn) begin
            mask_reg <= mask_reg | hwdata;
        end else if (wClr) begin
            mask_reg <= mask_reg & ~hwdata;
        end
    end
    // Edge capture wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pend_reg <= 32'h0;
        end else begin
            pend_reg <= ((pend_reg & ~({32{wPclr}} & hwdata))
                | srcRise | ({32{wSet}} & hwdata));
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            forceEn_reg <= 32'h0;
        end else if (wFfer) begin
            forceEn_reg <= forceEn_reg | (hwdata & 32'hFFFFFFFE);
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            spuVec_reg <= 32'h0;
        end else if (wSpu) begin
            spuVec_reg <= hwdata;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            debug_reg <= 2'h0;
        end else if (wDbg) begin
            debug_reg <= hwdata[1:0];
        end
    end

    // ============================================================
    // Service tracking: lowest-numbered active normal source
    logic [31:0] active;
    assign active = pend_reg & mask_reg;
    logic [31:0] normReq;
    assign normReq = active & ~forceEn_reg & 32'hFFFFFFFE;
    logic fastReq;
    assign fastReq = active[0] | (|(active & forceEn_reg));
    viu_src_t pick;
    logic pickValid;
    always_comb begin
        pick = 5'h00;
        pickValid = 1'b0;
        for (int i = 31; i >= 1; i--) begin
            if (normReq[i]) begin
                pick = 5'(i);
                pickValid = 1'b1;
            end
        end
    end
    viu_state_t state_reg;
    viu_src_t cur_reg;
    logic isNvrRead;
    assign isNvrRead = rdPend_reg && addr_reg == `VIU_OFF_NVR;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= VIU_IDLE;
            cur_reg <= 5'h00;
        end else begin
            case (state_reg)
                VIU_IDLE: begin
                    if (isNvrRead && pickValid) begin
                        state_reg <= VIU_SERV;
                        cur_reg <= pick;
                    end
                end
                VIU_SERV: begin
                    if (wEos) begin
                        state_reg <= VIU_IDLE;
                    end
                end
                default: state_reg <= VIU_IDLE;
            endcase
        end
    end

    // ============================================================
    // Core request lines
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            normalRequestLine_n <= 1'b1;
            fastRequestLine_n <= 1'b1;
        end else if (debug_reg[`VIU_DBG_LINE_MASK]) begin
            normalRequestLine_n <= 1'b1;
            fastRequestLine_n <= 1'b1;
        end else begin
            normalRequestLine_n <= !(pickValid && state_reg == VIU_IDLE);
            fastRequestLine_n <= !fastReq;
        end
    end

    // ============================================================
    // Event status: end of service and spurious vector read
    logic [1:0] evSt_reg, evMsk_reg, evHit;
    assign evHit = {isNvrRead && !pickValid && state_reg == VIU_IDLE, wEos};
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            evSt_reg <= 2'h0;
            evMsk_reg <= 2'h0;
            eventIrq <= 1'b0;
        end else begin
            evSt_reg <= (evSt_reg & ~({2{wEvst}} & hwdata[1:0])) | evHit;
            if (wEvmsk) begin
                evMsk_reg <= hwdata[1:0];
            end
            eventIrq <= |(evSt_reg & evMsk_reg);
        end
    end

    // ============================================================
    // Read data, answered in the data phase with no wait state
    viu_word_t rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (addr_reg == `VIU_OFF_NVR) begin
            rdMux = spuVec_reg;
            if (pickValid && state_reg == VIU_IDLE) begin
                rdMux = {27'h0, pick};
            end
        end else if (addr_reg == `VIU_OFF_FVR) begin
            rdMux = spuVec_reg;
        end else if (addr_reg == `VIU_OFF_ISR) begin
            rdMux = {27'h0, cur_reg};
        end else if (addr_reg == `VIU_OFF_IPR) begin
            rdMux = pend_reg;
        end else if (addr_reg == `VIU_OFF_IMR) begin
            rdMux = mask_reg;
        end else if (addr_reg == `VIU_OFF_CISR) begin
            rdMux = {30'h0, !normalRequestLine_n, !fastRequestLine_n};
        end else if (addr_reg == `VIU_OFF_SPU) begin
            rdMux = spuVec_reg;
        end else if (addr_reg == `VIU_OFF_DBG) begin
            rdMux = {30'h0, debug_reg};
        end else if (addr_reg == `VIU_OFF_EVST) begin
            rdMux = {30'h0, evSt_reg};
        end else if (addr_reg == `VIU_OFF_EVMSK) begin
            rdMux = {30'h0, evMsk_reg};
        end
    end
    assign hrdata = rdPend_reg ? rdMux : 32'h0;
    // The handshake never waits; registering it keeps hreadyout and hresp on a flop (hrdata stays combinational),
    // at the cost of an unknown level until the first edge after power-up
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ============================================================
    // Checks
    chk_gmask_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(debug_reg[1]) |-> normalRequestLine_n && fastRequestLine_n)
        else $error("request line active under general mask");
    chk_enable_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        wEn |=> ((mask_reg & $past(hwdata)) == $past(hwdata)))
        else $error("enable command did not set mask");
    chk_disable_clr: assert property (@(posedge core_clk) disable iff (!reset_n)
        wClr |=> ((mask_reg & $past(hwdata)) == 32'h0))
        else $error("disable command did not clear mask");
    chk_set_pend: assert property (@(posedge core_clk) disable iff (!reset_n)
        wSet |=> ((pend_reg & $past(hwdata)) == $past(hwdata)))
        else $error("set command did not pend");
    chk_clear_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
        wPclr && !wSet && srcRise == 32'h0 |=> ((pend_reg & $past(hwdata)) == 32'h0))
        else $error("clear command left request pending");
    chk_eos_ends: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == VIU_SERV && wEos |=> state_reg == VIU_IDLE)
        else $error("end of service not taken");
    chk_spu_store: assert property (@(posedge core_clk) disable iff (!reset_n)
        wSpu |=> spuVec_reg == $past(hwdata))
        else $error("spurious vector not stored");
    chk_ffer_bit0: assert property (@(posedge core_clk) disable iff (!reset_n)
        forceEn_reg[0] == 1'b0)
        else $error("fast source marked forced");
    chk_cmd_readzero: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_IECR |-> hrdata == 32'h0)
        else $error("command register read not zero");

    // ============================================================
    // Checks: read data on the register bus
    chk_pend_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_IPR |-> hrdata == pend_reg)
        else $error("pending read differs from pending state");
    chk_mask_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_IMR |-> hrdata == mask_reg)
        else $error("mask read differs from mask state");
    // Bit positions come from the field constants, not from the read mux
    chk_core_status: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_CISR |-> hrdata[`VIU_CL_FAST] == !fastRequestLine_n
        && hrdata[`VIU_CL_NORM] == !normalRequestLine_n)
        else $error("core line status does not match the lines");
    chk_spu_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_SPU |-> hrdata == spuVec_reg)
        else $error("spurious vector read differs from stored value");
    chk_fvr_spur: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_FVR |-> hrdata == spuVec_reg)
        else $error("fast vector read did not return spurious vector");
    chk_nvr_spur: assert property (@(posedge core_clk) disable iff (!reset_n)
        isNvrRead && !pickValid |-> hrdata == spuVec_reg)
        else $error("normal vector read with nothing active not spurious");
    chk_debug_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && addr_reg == `VIU_OFF_DBG |-> hrdata == {30'h0, debug_reg})
        else $error("debug control read differs from stored bits");
    chk_cmd_zero_all: assert property (@(posedge core_clk) disable iff (!reset_n)
        rdPend_reg && (addr_reg == `VIU_OFF_IDCR || addr_reg == `VIU_OFF_ICCR
        || addr_reg == `VIU_OFF_ISCR || addr_reg == `VIU_OFF_EOS
        || addr_reg == `VIU_OFF_FFER) |-> hrdata == 32'h0)
        else $error("write-only location read not zero");
    chk_idle_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        !rdPend_reg |-> hrdata == 32'h0)
        else $error("read data driven outside a read data phase");

    // ============================================================
    // Checks: command writes and stored state
    chk_enable_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
        wEn |=> (mask_reg & ~$past(hwdata)) == ($past(mask_reg) & ~$past(hwdata)))
        else $error("enable command changed an unwritten mask bit");
    chk_disable_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
        wClr |=> (mask_reg & ~$past(hwdata)) == ($past(mask_reg) & ~$past(hwdata)))
        else $error("disable command changed an unwritten mask bit");
    chk_ro_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wrPend_reg && addr_reg == `VIU_OFF_IMR |=> mask_reg == $past(mask_reg))
        else $error("write to mask status changed the mask");
    chk_pend_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        pend_reg == 32'h0 && srcRise == 32'h0 && !wSet |=> pend_reg == 32'h0)
        else $error("pending bit appeared without a request");
    chk_pend_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
        srcRise != 32'h0 |=> (pend_reg & $past(srcRise)) == $past(srcRise))
        else $error("source edge did not set its pending bit");
    chk_spu_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wSpu |=> spuVec_reg == $past(spuVec_reg))
        else $error("spurious vector changed without a write");
    chk_dbg_store: assert property (@(posedge core_clk) disable iff (!reset_n)
        wDbg |=> debug_reg[`VIU_DBG_PROTECTION] == $past(hwdata[`VIU_DBG_PROTECTION]))
        else $error("protection mode bit not stored");
    chk_ffer_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        wFfer |=> (forceEn_reg & $past(hwdata) & 32'hFFFFFFFE)
        == ($past(hwdata) & 32'hFFFFFFFE))
        else $error("fast forcing not enabled for written sources");

    // ============================================================
    // Checks: service tracking, request lines and events
    // Lines are registered, so each check looks one edge back
    chk_lines_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
        !$past(debug_reg[`VIU_DBG_LINE_MASK]) |-> fastRequestLine_n == !$past(fastReq)
        && normalRequestLine_n == !($past(pickValid) && $past(state_reg) == VIU_IDLE))
        else $error("request lines do not follow arbitration");
    chk_serv_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == VIU_SERV |=> normalRequestLine_n)
        else $error("normal line active while a source is in service");
    chk_fast_forced: assert property (@(posedge core_clk) disable iff (!reset_n)
        !$past(debug_reg[`VIU_DBG_LINE_MASK]) && $past(|(pend_reg & mask_reg & forceEn_reg))
        |-> !fastRequestLine_n)
        else $error("forced source did not raise the fast line");
    chk_nvr_enter: assert property (@(posedge core_clk) disable iff (!reset_n)
        isNvrRead && pickValid && state_reg == VIU_IDLE |=> state_reg == VIU_SERV
        && cur_reg == $past(pick))
        else $error("vector read did not start service of the chosen source");
    chk_eos_any: assert property (@(posedge core_clk) disable iff (!reset_n)
        wEos |=> state_reg == VIU_IDLE && evSt_reg[`VIU_EV_EOS])
        else $error("end of service write not taken as completion");
    chk_spur_event: assert property (@(posedge core_clk) disable iff (!reset_n)
        isNvrRead && !pickValid && state_reg == VIU_IDLE |=> evSt_reg[`VIU_EV_SPUR])
        else $error("spurious vector read not recorded");
    chk_event_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
        evSt_reg[`VIU_EV_EOS] && evMsk_reg[`VIU_EV_EOS] |=> eventIrq)
        else $error("unmasked end of service event did not raise the interrupt");
    cov_service: cover property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == VIU_IDLE ##1 state_reg == VIU_SERV);
    cov_gmask: cover property (@(posedge core_clk) disable iff (!reset_n)
        debug_reg[1] && pickValid);
    cov_fast: cover property (@(posedge core_clk) disable iff (!reset_n) !fastRequestLine_n);
    cov_spur: cover property (@(posedge core_clk) disable iff (!reset_n) evHit[1]);
    cov_eos_return: cover property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == VIU_SERV ##1 state_reg == VIU_IDLE);
endmodule : viu_core
`default_nettype wire

// ==== viu_src_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Interrupt sources and core request inputs
module viu_src_model (
    // Clock
    input wire logic core_clk,
    // Request lines as the core sees them
    input wire logic normalRequestLine_n,
    input wire logic fastRequestLine_n,
    // Source levels
    output var viu_pkg::viu_word_t srcIn
);
    import viu_pkg::*;
    int requestCycles = 0;
    initial srcIn = 32'h0;
    // A raised source level stays high for the rest of the run; nothing lowers it
    task raise(input int n);
        @(posedge core_clk);
        srcIn[n] <= 1'b1;
    endtask : raise
    always @(posedge core_clk) begin
        if (!normalRequestLine_n || !fastRequestLine_n) begin
            requestCycles++;
        end
    end
endmodule : viu_src_model
`default_nettype wire

// ==== tb_interrupt_status_and_command_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.svh"
module tb_interrupt_status_and_command_regs;
    import viu_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic normalRequestLine_n;
    logic fastRequestLine_n;
    logic eventIrq;
    viu_word_t srcIn;
    viu_word_t expQ[$];
    viu_word_t r1;
    viu_word_t r2;
    logic [11:0] cmdOffs[6];
    logic rdPend = 1'b0;
    int failures = 0;
    int comparisons = 0;
    int seed = 32'hFB06;
    viu_core DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .srcIn(srcIn), .normalRequestLine_n(normalRequestLine_n),
        .fastRequestLine_n(fastRequestLine_n), .eventIrq(eventIrq));
    viu_src_model SRC (.core_clk(core_clk), .normalRequestLine_n(normalRequestLine_n),
        .fastRequestLine_n(fastRequestLine_n), .srcIn(srcIn));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ==========================================
    // Reporting
    task complete_run;
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task chkWord(input viu_word_t e, input viu_word_t a);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("unexpected at %0t: read %h, wanted %h", $time, a, e);
        end
    endtask : chkWord
    task chkBit(input logic e, input logic a);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("unexpected at %0t: level %b, wanted %b", $time, a, e);
        end
    endtask : chkBit
    // ==========================================
    // Bus master; read expectations go to the queue
    task bus(input logic w, input logic [11:0] a, input viu_word_t d, input viu_word_t e);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) expQ.push_back(e);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask : bus
    task rd(input logic [11:0] a, input viu_word_t e);
        bus(1'b0, a, 32'h0, e);
    endtask : rd
    task wr(input logic [11:0] a, input viu_word_t d);
        bus(1'b1, a, d, 32'h0);
    endtask : wr
    task waitEdges;
        repeat (3) @(posedge core_clk);
    endtask : waitEdges
    // Read data is judged at the edge that closes its data phase
    always @(posedge core_clk) begin
        if (rdPend) chkWord(expQ.pop_front(), hrdata);
        rdPend = hsel && htrans[1] && !hwrite && (hreadyout === 1'b1);
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        failures++;
        complete_run();
    end
    // ==========================================
    // Scenarios
    initial begin
        cmdOffs = '{`VIU_OFF_IECR, `VIU_OFF_IDCR, `VIU_OFF_ICCR, `VIU_OFF_ISCR,
            `VIU_OFF_EOS, `VIU_OFF_FFER};
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(`VIU_OFF_ISR, 32'h0);
        rd(`VIU_OFF_IPR, 32'h0);
        rd(`VIU_OFF_IMR, 32'h0);
        rd(`VIU_OFF_CISR, 32'h0);
        rd(`VIU_OFF_SPU, 32'h0);
        rd(`VIU_OFF_DBG, 32'h0);
        foreach (cmdOffs[i]) rd(cmdOffs[i], 32'h0);
        rd(12'h200, 32'h0);
        r1 = $random(seed);
        r2 = $random(seed);
        wr(`VIU_OFF_SPU, r1);
        rd(`VIU_OFF_SPU, r1);
        rd(`VIU_OFF_NVR, r1);
        rd(`VIU_OFF_FVR, r1);
        wr(`VIU_OFF_IMR, r2);
        rd(`VIU_OFF_IMR, 32'h0);
        chkBit(1'b0, hresp);
        wr(`VIU_OFF_IECR, r1);
        wr(`VIU_OFF_IECR, r2);
        rd(`VIU_OFF_IMR, r1 | r2);
        wr(`VIU_OFF_IDCR, r2);
        rd(`VIU_OFF_IMR, r1 & ~r2);
        wr(`VIU_OFF_IDCR, 32'hFFFFFFFF);
        wr(`VIU_OFF_ISCR, r1);
        rd(`VIU_OFF_IPR, r1);
        wr(`VIU_OFF_ISCR, r2);
        wr(`VIU_OFF_ICCR, r1);
        rd(`VIU_OFF_IPR, r2 & ~r1);
        wr(`VIU_OFF_ICCR, 32'hFFFFFFFF);
        SRC.raise(5);
        repeat (6) @(posedge core_clk);
        rd(`VIU_OFF_IPR, 32'h20);
        wr(`VIU_OFF_IECR, 32'h20);
        waitEdges();
        chkBit(1'b0, normalRequestLine_n);
        chkBit(1'b1, fastRequestLine_n);
        rd(`VIU_OFF_CISR, 32'h2);
        wr(`VIU_OFF_DBG, 32'h2);
        waitEdges();
        chkBit(1'b1, normalRequestLine_n);
        rd(`VIU_OFF_CISR, 32'h0);
        rd(`VIU_OFF_DBG, 32'h2);
        wr(`VIU_OFF_DBG, 32'h1);
        rd(`VIU_OFF_DBG, 32'h1);
        chkBit(1'b0, normalRequestLine_n);
        rd(`VIU_OFF_NVR, 32'h5);
        rd(`VIU_OFF_ISR, 32'h5);
        chkBit(1'b1, normalRequestLine_n);
        wr(`VIU_OFF_EOS, $random(seed));
        waitEdges();
        chkBit(1'b0, eventIrq);
        wr(`VIU_OFF_EVMSK, 32'h1);
        waitEdges();
        chkBit(1'b1, eventIrq);
        wr(`VIU_OFF_EVST, 32'h3);
        waitEdges();
        chkBit(1'b0, eventIrq);
        wr(`VIU_OFF_FFER, 32'h21);
        waitEdges();
        chkBit(1'b0, fastRequestLine_n);
        rd(`VIU_OFF_CISR, 32'h1);
        chkBit(1'b1, SRC.requestCycles > 0);
        @(posedge core_clk);
        complete_run();
    end
endmodule : tb_interrupt_status_and_command_regs
`default_nettype wire
